// file: design/dfc_fault_config_regs.sv
`timescale 1ns/100ps
// How it works
// - Fault-read command 0xf6 returns the flag word in the next frame.
// - Over-temperature with protection on sets the trip flag and shuts down.
// - Frame lengths other than 24 or whole multiples of 32 set clock flag.
// - A checked frame whose checksum mismatches sets the checksum flag.
// - Flags stay set until power-up, clear pin, soft reset or fault write.
// - Any fault pulls the fault pin low until the next select rising edge.
// - Fault write 0x76 carries trip, clock and checksum flags in bits 2..0.
// - Config write 0x70: soft reset in bit 15, three settings in bits 2..0.
// - Writing soft reset resets the chip; the bit always reads zero.
// - Thermal guard off inhibits thermal shutdown; default protection on.
// - External reference bit selects outside reference, stops comp charging.
// - Checksum polynomial is x^6 + x + 1.
// - A frame failing its checksum is dropped and raises a fault.
// - Checksum checking runs only while its enable bit is one.
// - Config and fault reads and writes are never checksum checked.
// - Config-read command 0xf0 returns settings in the next frame.
// - Soft reset or a clear pulse powers up all channels.
// - The serial output floats while the select line is high.
module dfc_fault_config_regs
    import dfc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        sck,
    input  wire logic        sdi,
    input  wire logic        select_load_n,
    input  wire logic        clear_in_n,
    input  wire logic        over_temp_in,
    output logic             sdo_o,
    output logic             sdo_oe,
    output logic             fault_o,
    output logic             fault_oe,
    output logic             thermal_shutdown,
    output logic             thermal_guard_off,
    output logic             outside_vref_select,
    output logic             vref_comp_charge_en,
    output logic             soft_reset_pulse,
    output logic             channels_power_up,
    output logic [2:0]       fault_flags,
    output logic             exec_valid,
    output logic [23:0]      exec_word
);

    // Everything the core remembers, registered in one place.
    typedef struct packed {
        logic        cs_s1;
        logic        cs_s2;
        logic        cs_d;
        logic        ot_s1;
        logic        ot_s2;
        logic        clr_s1;
        logic        clr_s2;
        logic        clr_d;
        logic [2:0]  flags;
        logic        guard_off;
        logic        vref_ext;
        logic        crc_on;
        logic        comp_chg;
        logic        fault_low;
        logic        tsd_active;
        logic [23:0] reply;
        logic [23:0] exec_word;
        logic        exec_valid;
        logic        soft_rst;
        logic        pwr_up;
    } dfc_core_s;

    // Select and clear idle high, so their synchronisers start high too.
    localparam dfc_core_s CORE_RST = '{
        cs_s1      : 1'b1,
        cs_s2      : 1'b1,
        cs_d       : 1'b1,
        ot_s1      : 1'b0,
        ot_s2      : 1'b0,
        clr_s1     : 1'b1,
        clr_s2     : 1'b1,
        clr_d      : 1'b1,
        flags      : FLAGS_RST,
        guard_off  : CFG_RST,
        vref_ext   : CFG_RST,
        crc_on     : CFG_RST,
        comp_chg   : ~CFG_RST,
        fault_low  : 1'b0,
        tsd_active : 1'b0,
        reply      : REPLY_RST,
        exec_word  : REPLY_RST,
        exec_valid : 1'b0,
        soft_rst   : 1'b0,
        pwr_up     : 1'b0
    };

    dfc_core_s s_q;
    dfc_core_s s_d;

    dfc_frame_if frame ();

    // Serial side: runs on the host's clock, which stops between frames.
    dfc_spi_link u_link (
        .sck           (sck),
        .select_load_n (select_load_n),
        .sdi           (sdi),
        .sdo_o         (sdo_o),
        .sdo_oe        (sdo_oe),
        .frame         (frame.link)
    );

    // Checksum of the command word, shifted MSB first from all zero.
    function automatic logic [5:0] dfc_crc6(input logic [23:0] d);
        logic [5:0] c;
        logic       fb;
        c = CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            fb = c[5] ^ d[i];
            c  = {c[4:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction

    // Frame decode: these read the link outputs only after the select line
    // has been seen high through two flops, by which time sck is idle and
    // the shift register is stable, so the words cross without tearing.
    logic        frame_end;
    logic        len_ok;
    logic        is_short;
    logic [23:0] word;
    logic [5:0]  crc_rx;
    logic [7:0]  cmd;
    logic        exempt;
    logic        crc_bad;
    logic        ev_trip;
    logic        ev_clock;
    logic        ev_crc;
    logic        do_exec;
    logic        clr_fall;

    always_comb begin
        frame_end = s_q.cs_s2 & ~s_q.cs_d;
        is_short  = ~frame.rx_wrapped;
        // Only a 24-clock frame or a whole multiple of 32 is legal.
        len_ok = (frame.rx_wrapped && frame.rx_cnt_low == CNT_WHOLE)
               || (!frame.rx_wrapped && frame.rx_cnt_low == CNT_SHORT);
        // In a long frame the word sits ahead of the appended checksum.
        word   = is_short ? frame.rx_bits[23:0] : frame.rx_bits[31:8];
        crc_rx = frame.rx_bits[5:0];
        cmd    = word[CMD_MSB:CMD_LSB];
        exempt = (cmd == CMD_CFG_WR) || (cmd == CMD_FLT_WR)
               || (cmd == CMD_CFG_RD) || (cmd == CMD_FLT_RD);
        // A short frame has no room for a checksum, so it cannot pass.
        crc_bad = s_q.crc_on && !exempt
               && (is_short || dfc_crc6(word) != crc_rx);
        ev_trip  = s_q.ot_s2 & ~s_q.guard_off;
        ev_clock = frame_end & ~len_ok;
        ev_crc   = frame_end & len_ok & crc_bad;
        do_exec  = frame_end & len_ok & ~crc_bad;
        clr_fall = s_q.clr_d & ~s_q.clr_s2;
    end

    // Next-state logic of the core.
    always_comb begin
        s_d = s_q;
        s_d.exec_valid = 1'b0;
        s_d.soft_rst   = 1'b0;
        s_d.pwr_up     = 1'b0;

        // Pin inputs pass two flops; the third select stage finds edges.
        s_d.cs_s1  = select_load_n;
        s_d.cs_s2  = s_q.cs_s1;
        s_d.cs_d   = s_q.cs_s2;
        s_d.ot_s1  = over_temp_in;
        s_d.ot_s2  = s_q.ot_s1;
        s_d.clr_s1 = clear_in_n;
        s_d.clr_s2 = s_q.clr_s1;
        s_d.clr_d  = s_q.clr_s2;

        // Each closed frame releases the pin and drops the old answer.
        if (frame_end) begin
            s_d.fault_low = 1'b0;
            s_d.reply     = REPLY_RST;
        end

        // Commands run only from frames that passed length and checksum.
        if (do_exec) begin
            case (cmd)
                CMD_CFG_WR: begin
                    if (word[SOFT_RST_BIT]) begin
                        // The soft reset bit is not stored, so it reads 0.
                        s_d.flags      = FLAGS_RST;
                        s_d.guard_off  = CFG_RST;
                        s_d.vref_ext   = CFG_RST;
                        s_d.crc_on     = CFG_RST;
                        s_d.tsd_active = 1'b0;
                        s_d.soft_rst   = 1'b1;
                        s_d.pwr_up     = 1'b1;
                    end else begin
                        s_d.guard_off = word[GUARD_BIT];
                        s_d.vref_ext  = word[VREF_BIT];
                        s_d.crc_on    = word[CRC_EN_BIT];
                    end
                end
                CMD_FLT_WR: begin
                    s_d.flags = word[2:0];
                    if (!word[TRIP_BIT]) begin
                        s_d.tsd_active = 1'b0;
                    end
                end
                CMD_CFG_RD: begin
                    s_d.reply = {cmd, 13'h0000, s_q.guard_off,
                                 s_q.vref_ext, s_q.crc_on};
                end
                CMD_FLT_RD: begin
                    s_d.reply = {cmd, 13'h0000, s_q.flags};
                end
                default: begin
                    // Other commands go on to the rest of the device.
                    s_d.exec_valid = 1'b1;
                    s_d.exec_word  = word;
                end
            endcase
        end

        // A low clear pin holds settings and answer at defaults, and flags and shutdown unless a new event sets them;
        // its falling edge also brings every channel out of power-down.
        if (!s_q.clr_s2) begin
            s_d.flags      = FLAGS_RST;
            s_d.guard_off  = CFG_RST;
            s_d.vref_ext   = CFG_RST;
            s_d.crc_on     = CFG_RST;
            s_d.tsd_active = 1'b0;
            s_d.reply      = REPLY_RST;
        end
        if (clr_fall) begin
            s_d.pwr_up = 1'b1;
        end

        // New events come last so a set in a clearing cycle is not lost.
        if (ev_trip) begin
            s_d.flags[TRIP_BIT] = 1'b1;
            s_d.tsd_active      = 1'b1;
        end
        if (ev_clock) begin
            s_d.flags[CLOCK_BIT] = 1'b1;
        end
        if (ev_crc) begin
            s_d.flags[CRC_BIT] = 1'b1;
        end
        if (ev_trip || ev_clock || ev_crc) begin
            s_d.fault_low = 1'b1;
        end

        // Disabling the guard lifts any shutdown already in force.
        if (s_d.guard_off) begin
            s_d.tsd_active = 1'b0;
        end
        s_d.comp_chg = ~s_d.vref_ext;
    end

    // Registers; a low clock enable freezes the whole core.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q <= CORE_RST;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // The answer changes only at a frame end, while sck is idle, or while the clear pin is low.
    assign frame.tx_word = s_q.reply;

    // Open-drain fault pin: only ever drives low.
    assign fault_o  = 1'b0;
    assign fault_oe = s_q.fault_low;

    assign thermal_shutdown    = s_q.tsd_active;
    assign thermal_guard_off   = s_q.guard_off;
    assign outside_vref_select = s_q.vref_ext;
    assign vref_comp_charge_en = s_q.comp_chg;
    assign soft_reset_pulse    = s_q.soft_rst;
    assign channels_power_up   = s_q.pwr_up;
    assign fault_flags         = s_q.flags;
    assign exec_valid          = s_q.exec_valid;
    assign exec_word           = s_q.exec_word;

endmodule

// file: design/dfc_pkg.sv
package dfc_pkg;

    // Command codes carried in the top byte of the 24-bit command word.
    localparam logic [7:0] CMD_CFG_WR = 8'h70;
    localparam logic [7:0] CMD_FLT_WR = 8'h76;
    localparam logic [7:0] CMD_CFG_RD = 8'hf0;
    localparam logic [7:0] CMD_FLT_RD = 8'hf6;

    // Field positions inside the 24-bit command word.
    localparam int CMD_MSB      = 23;
    localparam int CMD_LSB      = 16;
    localparam int SOFT_RST_BIT = 15;
    localparam int GUARD_BIT    = 2;
    localparam int VREF_BIT     = 1;
    localparam int CRC_EN_BIT   = 0;

    // Positions of the flags in the fault flag word.
    localparam int TRIP_BIT  = 2;
    localparam int CLOCK_BIT = 1;
    localparam int CRC_BIT   = 0;

    // Frame lengths: a 24-clock frame or any whole multiple of 32 clocks.
    localparam logic [4:0] CNT_SHORT = 5'h18;
    localparam logic [4:0] CNT_WHOLE = 5'h00;
    localparam logic [4:0] CNT_TOP   = 5'h1f;

    // Checksum generator x^6 + x + 1, shifted MSB first from all zero.
    localparam logic [5:0] CRC_POLY = 6'h03;
    localparam logic [5:0] CRC_INIT = 6'h00;

    // Values after reset.
    localparam logic [2:0]  FLAGS_RST = 3'h0;
    localparam logic        CFG_RST   = 1'b0;
    localparam logic [23:0] REPLY_RST = 24'h000000;

    // Die temperature at which the external sensor raises its trip input.
    localparam int TRIP_TEMP_C = 160;

endpackage

// file: design/dfc_frame_if.sv
`timescale 1ns/100ps
// Carries a finished frame from the serial clock domain to the core and
// the answer word back; the core reads only while the serial clock idles, the link while it shifts.
interface dfc_frame_if;
    logic [31:0] rx_bits;
    logic [4:0]  rx_cnt_low;
    logic        rx_wrapped;
    logic [23:0] tx_word;

    modport link (
        output rx_bits,
        output rx_cnt_low,
        output rx_wrapped,
        input  tx_word
    );

    modport core (
        input  rx_bits,
        input  rx_cnt_low,
        input  rx_wrapped,
        output tx_word
    );
endinterface

// file: design/dfc_spi_link.sv
`timescale 1ns/100ps
module dfc_spi_link
    import dfc_pkg::*;
(
    input  wire logic sck,
    input  wire logic select_load_n,
    input  wire logic sdi,
    output logic      sdo_o,
    output logic      sdo_oe,
    dfc_frame_if.link frame
);

    typedef struct packed {
        logic [31:0] sh;
        logic [4:0]  cnt;
        logic        wrap;
    } dfc_link_s;

    dfc_link_s st_q;
    dfc_link_s st_d;
    logic      armed_q;
    logic      sdo_q;

    // Shift in on rising edges; the first edge of a frame restarts the count.
    always_comb begin
        st_d = st_q;
        if (armed_q) begin
            st_d.sh   = {31'h00000000, sdi};
            st_d.cnt  = 5'h01;
            st_d.wrap = 1'b0;
        end else begin
            st_d.sh  = {st_q.sh[30:0], sdi};
            st_d.cnt = st_q.cnt + 5'h01;
            if (st_q.cnt == CNT_TOP) begin
                st_d.wrap = 1'b1;
            end
        end
    end

    // No reset here: the data is only read once a frame has closed.
    always_ff @(posedge sck) begin
        st_q <= st_d;
    end

    // The select line arms a new frame; sck is idle whenever it is high.
    always_ff @(posedge sck or posedge select_load_n) begin
        if (select_load_n) begin
            armed_q <= 1'b1;
        end else begin
            armed_q <= 1'b0;
        end
    end

    // Answer bits change on falling edges so the host samples them stably.
    always_ff @(negedge sck) begin
        if (!st_q.wrap && st_q.cnt < CNT_SHORT) begin
            sdo_q <= frame.tx_word[5'h17 - st_q.cnt];
        end else begin
            sdo_q <= 1'b0;
        end
    end

    // The first answer bit is shown before any clock edge of the frame.
    assign sdo_o  = armed_q ? frame.tx_word[23] : sdo_q;
    assign sdo_oe = ~select_load_n;

    assign frame.rx_bits    = st_q.sh;
    assign frame.rx_cnt_low = st_q.cnt;
    assign frame.rx_wrapped = st_q.wrap;

endmodule

// file: dv/dfc_host_model.sv
`timescale 1ns/100ps
// Serial host: the clock stands low outside frames and runs at 64 ns.
module dfc_host_model (
    output logic      sck,
    output logic      sdi,
    output logic      select_load_n,
    input  wire logic sdo_o,
    input  wire logic sdo_oe
);
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        // A late first rise gives the link's arming flop a real edge.
        #1 select_load_n = 1'b1;
    end

    // Checksum over the 24 word bits, MSB first, from an all-zero start.
    function automatic logic [5:0] crc6(input logic [23:0] d);
        logic [5:0] c;
        c = 6'h00;
        for (int i = 23; i >= 0; i--) begin
            c = {c[4:0], 1'b0} ^ ((c[5] ^ d[i]) ? 6'h03 : 6'h00);
        end
        return c;
    endfunction

    // One frame; a bad checksum is made by flipping its lowest bit.
    task automatic xfer(input logic [23:0] w, input int n, input logic bad,
                        output logic [23:0] rx);
        logic [63:0] v;
        v = {32'h0, w, 2'b00, crc6(w) ^ {5'h00, bad}};
        if (n == 24) v = {40'h0, w};
        rx = 24'h000000;
        #7 select_load_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = v[i];
            #32;
            // Sample just before the rising edge, while the bit is settled.
            if (i >= n - 24) rx = {rx[22:0], sdo_oe === 1'b1 ? sdo_o : 1'bx};
            sck = 1'b1;
            #32 sck = 1'b0;
        end
        #32 select_load_n = 1'b1;
        sdi = ~sdi; // Released line shows the inverse, never a stale bit.
    endtask
endmodule

// file: dv/dfc_fault_config_regs_monitor.sv
`timescale 1ns/100ps
module dfc_fault_config_regs_monitor
    import dfc_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        clk_en,
    input wire logic        select_load_n,
    input wire logic        clear_in_n,
    input wire logic        over_temp_in,
    input wire logic        sdo_oe,
    input wire logic        fault_o,
    input wire logic        fault_oe,
    input wire logic        thermal_shutdown,
    input wire logic        thermal_guard_off,
    input wire logic        outside_vref_select,
    input wire logic        vref_comp_charge_en,
    input wire logic        soft_reset_pulse,
    input wire logic        channels_power_up,
    input wire logic [2:0]  fault_flags,
    input wire logic        exec_valid,
    input wire logic [23:0] exec_word
);
    default clocking cb @(posedge ref_clk); endclocking
    // A frozen core is not expected to react, so checks pause with it.
    default disable iff (sys_rst || !clk_en);

    // Four cycles of margin cover the two-flop synchronisers.
    property p_oe; sdo_oe == !select_load_n; endproperty
    property p_od; fault_o == 1'b0; endproperty
    property p_comp; vref_comp_charge_en == !outside_vref_select; endproperty
    property p_guard; thermal_guard_off [*2] |-> !thermal_shutdown; endproperty
    property p_clr; (!clear_in_n) [*4] |-> fault_flags == 3'h0
        && !thermal_guard_off && !outside_vref_select; endproperty
    property p_trip; (over_temp_in && !thermal_guard_off && clear_in_n) [*4]
        |-> fault_flags[TRIP_BIT] && thermal_shutdown; endproperty
    property p_rel; $fell(fault_oe) |-> select_load_n; endproperty
    property p_srst; soft_reset_pulse |-> channels_power_up
        ##1 !soft_reset_pulse; endproperty
    property p_exec; !exec_valid |-> $stable(exec_word); endproperty

    a_oe: assert property (p_oe)
        else $error("sdo enable does not follow select");
    a_od: assert property (p_od)
        else $error("fault pin value not low");
    a_comp: assert property (p_comp)
        else $error("comp charge not inverse of vref select");
    a_guard: assert property (p_guard)
        else $error("shutdown while guard off");
    a_clr: assert property (p_clr)
        else $error("clear pin did not hold defaults");
    a_trip: assert property (p_trip)
        else $error("over temperature not flagged");
    a_rel: assert property (p_rel)
        else $error("fault pin released while selected");
    a_srst: assert property (p_srst)
        else $error("soft reset pulse wrong");
    a_exec: assert property (p_exec)
        else $error("exec word changed without valid");

    c_exec: cover property (exec_valid);
    c_srst: cover property (soft_reset_pulse);
    c_rel: cover property ($fell(fault_oe));
endmodule

bind dfc_fault_config_regs dfc_fault_config_regs_monitor i_mon (
    .ref_clk, .sys_rst, .clk_en, .select_load_n, .clear_in_n, .over_temp_in,
    .sdo_oe, .fault_o, .fault_oe, .thermal_shutdown, .thermal_guard_off,
    .outside_vref_select, .vref_comp_charge_en, .soft_reset_pulse,
    .channels_power_up, .fault_flags, .exec_valid, .exec_word
);

// file: dv/dfc_fault_config_regs_tb.sv
`timescale 1ns/100ps
module dfc_fault_config_regs_tb
    import dfc_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        clear_in_n = 1'b1;
    logic        over_temp_in = 1'b0;
    logic        sck, sdi, select_load_n, sdo_o, sdo_oe, fault_o, fault_oe;
    logic        thermal_shutdown, thermal_guard_off, outside_vref_select;
    logic        vref_comp_charge_en, soft_reset_pulse, channels_power_up;
    logic        exec_valid, seen_exec, seen_srst, seen_pwr;
    logic [2:0]  fault_flags, r;
    logic [23:0] exec_word, seen_word, rx, w;
    int          fail_count = 0;
    int          tests_run = 0;
    int          lens [4] = '{25, 31, 33, 64};

    dfc_fault_config_regs i_dut (
        .ref_clk, .sys_rst, .clk_en, .sck, .sdi, .select_load_n,
        .clear_in_n, .over_temp_in, .sdo_o, .sdo_oe, .fault_o, .fault_oe,
        .thermal_shutdown, .thermal_guard_off, .outside_vref_select,
        .vref_comp_charge_en, .soft_reset_pulse, .channels_power_up,
        .fault_flags, .exec_valid, .exec_word
    );
    dfc_host_model i_host (.sck, .sdi, .select_load_n, .sdo_o, .sdo_oe);

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // Pulses last one core cycle, so they are latched for later checks.
    always @(posedge ref_clk) begin
        if (exec_valid === 1'b1) begin
            seen_exec <= 1'b1;
            seen_word <= exec_word;
        end
        if (soft_reset_pulse === 1'b1) seen_srst <= 1'b1;
        if (channels_power_up === 1'b1) seen_pwr <= 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic chk(input string nm, input logic [23:0] e, g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // A frame, then time for the core to see its end and answer.
    task automatic fr(input logic [23:0] wd, input int n, input logic bad);
        seen_exec = 1'b0;
        seen_srst = 1'b0;
        seen_pwr = 1'b0;
        i_host.xfer(wd, n, bad, rx);
        tick(8);
    endtask
    function automatic logic [23:0] rep(input logic [7:0] c,
                                        input logic [2:0] b);
        return {c, 13'h0000, b};
    endfunction
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Whole run is about 83 us; the limit leaves wide margin.
    initial begin
        #1000000;
        fail_count++;
        results();
    end

    initial begin
        void'($urandom(80));
        tick(3);
        sys_rst = 1'b0;
        tick(6);
        fr({CMD_CFG_RD, 16'h0000}, 24, 1'b0);
        fr({CMD_FLT_RD, 16'h0000}, 24, 1'b0);
        chk("cfg reset", rep(CMD_CFG_RD, 3'h0), rx);
        chk("comp reset", {23'h0, vref_comp_charge_en}, 24'h1);
        // Settings are written and read back, all ones first.
        for (int i = 0; i < 4; i++) begin
            r = (i == 0) ? 3'h7 : 3'($urandom);
            fr({CMD_CFG_WR, 13'h0000, r}, 24, 1'b0);
            fr({CMD_CFG_RD, 16'h0000}, 32, 1'b1);
            fr({CMD_FLT_RD, 16'h0000}, 24, 1'b0);
            chk("cfg read", rep(CMD_CFG_RD, r), rx);
            chk("no crc flag", {21'h0, fault_flags}, 24'h0);
            chk("vref", {23'h0, outside_vref_select}, {23'h0, r[1]});
            chk("guard", {23'h0, thermal_guard_off}, {23'h0, r[2]});
        end
        fr({CMD_CFG_WR, 16'h0000}, 24, 1'b0);
        // Frame lengths: only 24 or whole multiples of 32 are taken.
        foreach (lens[i]) begin
            fr(24'h000000, lens[i], 1'b0);
            chk("exec len", {23'h0, seen_exec}, {23'h0, lens[i] == 64});
            chk("fault pin", {23'h0, fault_oe}, {23'h0, lens[i] != 64});
            fr({CMD_FLT_RD, 16'h0000}, 24, 1'b0);
            fr({CMD_FLT_WR, 16'h0000}, 24, 1'b0);
            chk("flag read", rep(CMD_FLT_RD, {1'b0, lens[i] != 64, 1'b0}),
                rx);
            chk("flags cleared", {21'h0, fault_flags}, 24'h0);
            chk("pin released", {23'h0, fault_oe}, 24'h0);
        end
        r = 3'($urandom);
        fr({CMD_FLT_WR, 13'h0000, r}, 24, 1'b0);
        chk("flag write", {21'h0, fault_flags}, {21'h0, r});
        fr({CMD_FLT_WR, 16'h0000}, 24, 1'b0);
        // Checksum: off it is ignored, on it gates execution.
        w = {8'h30, 16'($urandom)};
        fr(w, 32, 1'b1);
        chk("crc off exec", {23'h0, seen_exec}, 24'h1);
        fr({CMD_CFG_WR, 16'h0001}, 24, 1'b0);
        fr(w, 32, 1'b0);
        chk("crc good", seen_word, w);
        chk("crc good flag", {21'h0, fault_flags}, 24'h0);
        fr(w, 32, 1'b1);
        chk("crc bad exec", {23'h0, seen_exec}, 24'h0);
        chk("crc bad flag", {21'h0, fault_flags}, 24'h1);
        chk("crc bad pin", {23'h0, fault_oe}, 24'h1);
        fr({CMD_FLT_WR, 16'h0000}, 32, 1'b1);
        chk("exempt write", {21'h0, fault_flags}, 24'h0);
        fr(w, 24, 1'b0);
        chk("short frame", {21'h0, fault_flags}, 24'h1);
        // Soft reset clears flags and settings and powers channels.
        fr({CMD_CFG_WR, 16'h8007}, 24, 1'b0);
        chk("srst pulse", {22'h0, seen_srst, seen_pwr}, 24'h3);
        chk("srst flags", {21'h0, fault_flags}, 24'h0);
        fr({CMD_CFG_RD, 16'h0000}, 24, 1'b0);
        fr({CMD_FLT_RD, 16'h0000}, 24, 1'b0);
        chk("srst cfg", rep(CMD_CFG_RD, 3'h0), rx);
        // Over temperature, guard off, then the clear pin.
        over_temp_in = 1'b1;
        tick(6);
        chk("trip", {21'h0, fault_flags}, 24'h4);
        chk("shutdown", {22'h0, thermal_shutdown, fault_oe}, 24'h3);
        fr({CMD_CFG_WR, 16'h0004}, 24, 1'b0);
        chk("guard off", {23'h0, thermal_shutdown}, 24'h0);
        over_temp_in = 1'b0;
        clk_en = 1'b0;
        clear_in_n = 1'b0;
        tick(6);
        chk("frozen", {23'h0, thermal_guard_off}, 24'h1);
        clk_en = 1'b1;
        tick(6);
        chk("clear", {20'h0, thermal_guard_off, fault_flags}, 24'h0);
        chk("clear power", {23'h0, seen_pwr}, 24'h1);
        clear_in_n = 1'b1;
        tick(6);
        results();
    end
endmodule
